// ---- hdl/cbo_pkg.sv ----
package cbo_pkg;

   // buffer count and bus geometry
   localparam int          NBUF      = 32;
   localparam int          HALF_W    = 16;
   localparam int          ADDR_W    = 8;
   localparam int          NPAIR     = NBUF / 2;

   // register byte offsets
   localparam logic [7:0]  OFS_OVF_LO   = 8'h00;
   localparam logic [7:0]  OFS_OVF_HI   = 8'h04;
   localparam logic [7:0]  OFS_FUL_LO   = 8'h08;
   localparam logic [7:0]  OFS_FUL_HI   = 8'h0c;
   localparam logic [7:0]  OFS_TXC_BASE = 8'h10;
   localparam logic [7:0]  OFS_TXC_END  = 8'h50;
   localparam logic [7:0]  OFS_INT_STAT = 8'h50;
   localparam logic [7:0]  OFS_INT_MASK = 8'h54;

   // control byte fields
   localparam int          BIT_DIR   = 7;
   localparam int          BIT_ABT   = 6;
   localparam int          BIT_ARB   = 5;
   localparam int          BIT_ERR   = 4;
   localparam int          BIT_REQ   = 3;
   localparam int          BIT_RTR   = 2;
   localparam int          PRI_HI    = 1;
   localparam int          PRI_LO    = 0;
   localparam int          PRI_W     = 2;
   localparam logic [7:0]  CTRL_RESET = 8'h00;

   // interrupt status layout
   localparam int          INT_W     = 3;
   localparam int          INT_OVF   = 0;
   localparam int          INT_DONE  = 1;
   localparam int          INT_ERR   = 2;

   // reset values
   localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
   localparam logic [2:0]  INT_RESET   = 3'h0;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

endpackage : cbo_pkg

// ---- hdl/cbo_ctrl_byte.sv ----
`timescale 1ns/1ns
module cbo_ctrl_byte (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // software write
   input  wire logic       wr_en,
   input  wire logic [7:0] wdata,
   // frame engine events for this buffer
   input  wire logic       done,
   input  wire logic       abort,
   input  wire logic       lost_arb,
   input  wire logic       fault,
   // control byte
   output logic      [7:0] ctrl_byte
);

   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;

   always_comb begin
      ctrl_nxt = ctrl_r;
      // hardware clears first so a software set in the same cycle survives
      if (done || abort) begin
         ctrl_nxt[cbo_pkg::BIT_REQ] = 1'b0;
      end
      if (wr_en) begin
         ctrl_nxt[cbo_pkg::BIT_DIR] = wdata[cbo_pkg::BIT_DIR];
         ctrl_nxt[cbo_pkg::BIT_RTR] = wdata[cbo_pkg::BIT_RTR];
         ctrl_nxt[cbo_pkg::PRI_HI:cbo_pkg::PRI_LO] =
            wdata[cbo_pkg::PRI_HI:cbo_pkg::PRI_LO];
         if (wdata[cbo_pkg::BIT_REQ]) begin
            ctrl_nxt[cbo_pkg::BIT_REQ] = 1'b1;
            // a fresh request starts with clean outcome flags
            ctrl_nxt[cbo_pkg::BIT_ABT] = 1'b0;
            ctrl_nxt[cbo_pkg::BIT_ARB] = 1'b0;
            ctrl_nxt[cbo_pkg::BIT_ERR] = 1'b0;
         end else begin
            ctrl_nxt[cbo_pkg::BIT_REQ] = 1'b0;
         end
      end
      if (done) begin
         ctrl_nxt[cbo_pkg::BIT_ABT] = 1'b0;
      end
      if (abort) begin
         ctrl_nxt[cbo_pkg::BIT_ABT] = 1'b1;
      end
      if (lost_arb) begin
         ctrl_nxt[cbo_pkg::BIT_ARB] = 1'b1;
      end
      if (fault) begin
         ctrl_nxt[cbo_pkg::BIT_ERR] = 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_r <= cbo_pkg::CTRL_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   assign ctrl_byte = ctrl_r;

endmodule : cbo_ctrl_byte

// ---- hdl/cbo_buf_status.sv ----
`timescale 1ns/1ns
module cbo_buf_status (
   // clock and reset
   input  wire logic                          mclk,
   input  wire logic                          rst,
   // apb slave
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [cbo_pkg::ADDR_W-1:0]    paddr,
   input  wire logic [31:0]                   pwdata,
   input  wire logic [3:0]                    pstrb,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   // receive side of the frame engine
   input  wire logic                          rx_store,
   input  wire logic [4:0]                    rx_index,
   // transmit side of the frame engine
   input  wire logic                          tx_done,
   input  wire logic                          tx_abort,
   input  wire logic                          tx_lost_arb,
   input  wire logic                          tx_fault,
   input  wire logic [4:0]                    tx_index,
   // buffer state toward the frame engine
   output logic      [cbo_pkg::NBUF-1:0]      rx_buffer_occupied,
   output logic      [cbo_pkg::NBUF-1:0]      send_request,
   output logic      [cbo_pkg::NBUF-1:0]      buffer_direction_select,
   output logic      [cbo_pkg::NBUF-1:0]      auto_remote_reply_enable,
   output logic      [2*cbo_pkg::NBUF-1:0]    send_priority,
   // interrupt
   output logic                               irq
);

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic logic [cbo_pkg::NBUF-1:0] one_hot(input logic [4:0] idx);
      one_hot = '0;
      one_hot[idx] = 1'b1;
   endfunction : one_hot

   function automatic logic reg_hit(input logic [cbo_pkg::ADDR_W-1:0] a,
                                    input logic [cbo_pkg::ADDR_W-1:0] ofs);
      reg_hit = (a == ofs);
   endfunction : reg_hit

   ////////////////////////////////////////////////////////////////////////////
   // state

   logic [cbo_pkg::NBUF-1:0]  ovf_r;
   logic [cbo_pkg::NBUF-1:0]  ovf_nxt;
   logic [cbo_pkg::NBUF-1:0]  ful_r;
   logic [cbo_pkg::NBUF-1:0]  ful_nxt;
   logic [cbo_pkg::INT_W-1:0] int_stat_r;
   logic [cbo_pkg::INT_W-1:0] int_stat_nxt;
   logic [cbo_pkg::INT_W-1:0] int_mask_r;
   logic [cbo_pkg::INT_W-1:0] int_mask_nxt;
   logic [31:0]               rdata_r;
   logic [31:0]               rdata_nxt;
   logic                      slverr_r;
   logic                      slverr_nxt;

   logic [7:0]                ctrl_w [cbo_pkg::NBUF];
   logic [cbo_pkg::NBUF-1:0]  ctrl_wr;
   logic                      setup;
   logic                      wr_acc;
   logic                      rd_acc;
   logic                      txc_hit;
   logic [3:0]                pair_idx;
   logic [cbo_pkg::ADDR_W-1:0] txc_ofs;
   logic [cbo_pkg::NBUF-1:0]  store_hot;
   logic [cbo_pkg::NBUF-1:0]  tx_hot;
   logic [cbo_pkg::NBUF-1:0]  ovf_set;
   logic                      addr_ok;

   assign setup    = psel && !penable;
   assign wr_acc   = psel && penable && pwrite;
   assign rd_acc   = psel && penable && !pwrite;
   assign txc_hit  = (paddr >= cbo_pkg::OFS_TXC_BASE) && (paddr < cbo_pkg::OFS_TXC_END)
                     && (paddr[1:0] == 2'h0);
   assign txc_ofs  = paddr - cbo_pkg::OFS_TXC_BASE;
   assign pair_idx = txc_ofs[5:2];
   assign store_hot = rx_store ? one_hot(rx_index) : '0;
   assign tx_hot    = one_hot(tx_index);
   assign ovf_set   = store_hot & ful_r;
   assign addr_ok   = reg_hit(paddr, cbo_pkg::OFS_OVF_LO) || reg_hit(paddr, cbo_pkg::OFS_OVF_HI)
                   || reg_hit(paddr, cbo_pkg::OFS_FUL_LO) || reg_hit(paddr, cbo_pkg::OFS_FUL_HI)
                   || reg_hit(paddr, cbo_pkg::OFS_INT_STAT)
                   || reg_hit(paddr, cbo_pkg::OFS_INT_MASK) || txc_hit;

   ////////////////////////////////////////////////////////////////////////////
   // per-buffer control bytes, two to a register word

   for (genvar b = 0; b < cbo_pkg::NBUF; b++) begin : g_buf
      assign ctrl_wr[b] = wr_acc && txc_hit && (pair_idx == 4'(b / 2)) && pstrb[b % 2];
      cbo_ctrl_byte u_ctrl (
         .mclk      (mclk),
         .rst       (rst),
         .wr_en     (ctrl_wr[b]),
         .wdata     (pwdata[8*(b%2) +: 8]),
         .done      (tx_done && tx_hot[b]),
         .abort     (tx_abort && tx_hot[b]),
         .lost_arb  (tx_lost_arb && tx_hot[b]),
         .fault     (tx_fault && tx_hot[b]),
         .ctrl_byte (ctrl_w[b])
      );
      assign send_request[b]             = ctrl_w[b][cbo_pkg::BIT_REQ];
      assign buffer_direction_select[b]  = ctrl_w[b][cbo_pkg::BIT_DIR];
      assign auto_remote_reply_enable[b] = ctrl_w[b][cbo_pkg::BIT_RTR];
      assign send_priority[2*b +: 2]     = ctrl_w[b][cbo_pkg::PRI_HI:cbo_pkg::PRI_LO];
   end

   ////////////////////////////////////////////////////////////////////////////
   // flag, interrupt and bus next state

   always_comb begin
      ovf_nxt      = ovf_r;
      ful_nxt      = ful_r;
      int_stat_nxt = int_stat_r;
      int_mask_nxt = int_mask_r;
      rdata_nxt    = rdata_r;
      slverr_nxt   = slverr_r;

      // software clears: a zero written in a bit clears it, a one leaves it
      if (wr_acc && pstrb[0] && pstrb[1]) begin
         if (reg_hit(paddr, cbo_pkg::OFS_OVF_LO)) begin
            ovf_nxt[15:0] = ovf_r[15:0] & pwdata[15:0];
         end
         if (reg_hit(paddr, cbo_pkg::OFS_OVF_HI)) begin
            ovf_nxt[31:16] = ovf_r[31:16] & pwdata[15:0];
         end
         if (reg_hit(paddr, cbo_pkg::OFS_FUL_LO)) begin
            ful_nxt[15:0] = ful_r[15:0] & pwdata[15:0];
         end
         if (reg_hit(paddr, cbo_pkg::OFS_FUL_HI)) begin
            ful_nxt[31:16] = ful_r[31:16] & pwdata[15:0];
         end
      end
      if (wr_acc && pstrb[0] && reg_hit(paddr, cbo_pkg::OFS_INT_MASK)) begin
         int_mask_nxt = pwdata[cbo_pkg::INT_W-1:0];
      end
      // clear only the bits the setup snapshot returned, so an event that lands
      // between the snapshot and the access edge is not lost unseen
      if (rd_acc && reg_hit(paddr, cbo_pkg::OFS_INT_STAT)) begin
         int_stat_nxt = int_stat_r & ~rdata_r[cbo_pkg::INT_W-1:0];
      end

      // hardware sets applied last so an event never loses to a clear
      ovf_nxt = ovf_nxt | ovf_set;
      ful_nxt = ful_nxt | store_hot;
      if (|ovf_set) begin
         int_stat_nxt[cbo_pkg::INT_OVF] = 1'b1;
      end
      if (tx_done) begin
         int_stat_nxt[cbo_pkg::INT_DONE] = 1'b1;
      end
      if (tx_fault || tx_abort) begin
         int_stat_nxt[cbo_pkg::INT_ERR] = 1'b1;
      end

      // read data is captured in the setup cycle so it leaves a flop
      if (setup) begin
         slverr_nxt = !addr_ok;
         rdata_nxt  = cbo_pkg::RDATA_RESET;
         if (!pwrite) begin
            if (reg_hit(paddr, cbo_pkg::OFS_OVF_LO)) begin
               rdata_nxt[15:0] = ovf_r[15:0];
            end
            if (reg_hit(paddr, cbo_pkg::OFS_OVF_HI)) begin
               rdata_nxt[15:0] = ovf_r[31:16];
            end
            if (reg_hit(paddr, cbo_pkg::OFS_FUL_LO)) begin
               rdata_nxt[15:0] = ful_r[15:0];
            end
            if (reg_hit(paddr, cbo_pkg::OFS_FUL_HI)) begin
               rdata_nxt[15:0] = ful_r[31:16];
            end
            if (reg_hit(paddr, cbo_pkg::OFS_INT_STAT)) begin
               rdata_nxt[cbo_pkg::INT_W-1:0] = int_stat_r;
            end
            if (reg_hit(paddr, cbo_pkg::OFS_INT_MASK)) begin
               rdata_nxt[cbo_pkg::INT_W-1:0] = int_mask_r;
            end
            if (txc_hit) begin
               rdata_nxt[15:0] = {ctrl_w[{pair_idx, 1'b1}], ctrl_w[{pair_idx, 1'b0}]};
            end
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ovf_r      <= cbo_pkg::FLAGS_RESET;
         ful_r      <= cbo_pkg::FLAGS_RESET;
         int_stat_r <= cbo_pkg::INT_RESET;
         int_mask_r <= cbo_pkg::INT_RESET;
         rdata_r    <= cbo_pkg::RDATA_RESET;
         slverr_r   <= 1'b0;
      end else begin
         ovf_r      <= ovf_nxt;
         ful_r      <= ful_nxt;
         int_stat_r <= int_stat_nxt;
         int_mask_r <= int_mask_nxt;
         rdata_r    <= rdata_nxt;
         slverr_r   <= slverr_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   // zero wait states: the access phase always completes in one cycle
   assign pready             = 1'b1;
   assign prdata             = rdata_r;
   assign pslverr            = slverr_r && psel && penable;
   assign rx_buffer_occupied = ful_r;
   assign irq                = |(int_stat_r & int_mask_r);

endmodule : cbo_buf_status

// ---- bench/cbo_engine_model.sv ----
`timescale 1ns/1ns
module cbo_engine_model (
   // clock
   input  wire logic  mclk,
   // per-buffer event pulses
   output logic       rx_store,
   output logic [4:0] rx_index,
   output logic       tx_done,
   output logic       tx_abort,
   output logic       tx_lost_arb,
   output logic       tx_fault,
   output logic [4:0] tx_index
);
   initial begin
      {rx_store, tx_done, tx_abort, tx_lost_arb, tx_fault} = 5'h00;
      rx_index = 5'h00;
      tx_index = 5'h00;
   end
   // kind: 0 stored, 1 sent, 2 aborted, 3 lost arbitration, 4 bus error
   task automatic fire(input int kind, input logic [4:0] idx);
      @(posedge mclk);
      rx_index <= idx;
      tx_index <= idx;
      {tx_fault, tx_lost_arb, tx_abort, tx_done, rx_store} <= 5'(1 << kind);
      @(posedge mclk);
      {rx_store, tx_done, tx_abort, tx_lost_arb, tx_fault} <= 5'h00;
      // index means nothing outside a pulse, so do not leave it valid
      rx_index <= ~idx;
      tx_index <= ~idx;
   endtask : fire
endmodule : cbo_engine_model

// ---- bench/cbo_buf_status_monitor.sv ----
`timescale 1ns/1ns
module cbo_buf_status_monitor (
   // clock and reset
   input wire logic        mclk,
   input wire logic        rst,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // frame engine
   input wire logic        rx_store,
   input wire logic [4:0]  rx_index,
   input wire logic        tx_done,
   input wire logic        tx_abort,
   input wire logic        tx_fault,
   input wire logic [4:0]  tx_index,
   // buffer state
   input wire logic [31:0] rx_buffer_occupied,
   input wire logic [31:0] send_request,
   input wire logic [31:0] buffer_direction_select,
   input wire logic        irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic acc_w, ful_w, ctl_w, isr_w;
   assign acc_w = psel && penable && pwrite;
   assign ful_w = acc_w && (paddr == cbo_pkg::OFS_FUL_LO || paddr == cbo_pkg::OFS_FUL_HI);
   assign ctl_w = acc_w && paddr >= cbo_pkg::OFS_TXC_BASE && paddr < cbo_pkg::OFS_TXC_END;
   assign isr_w = psel && penable && !pwrite && paddr == cbo_pkg::OFS_INT_STAT;
   ////////////////////////////////////////////////////////////////
   full_set_a: assert property (rx_store |=> rx_buffer_occupied[$past(rx_index)])
      else $error("store did not mark buffer full");
   full_clr_a: assert property (|($past(rx_buffer_occupied) & ~rx_buffer_occupied)
      |-> $past(ful_w)) else $error("full flag fell without a write");
   done_req_a: assert property (tx_done && !ctl_w |=> !send_request[$past(tx_index)])
      else $error("request kept after send");
   abort_req_a: assert property (tx_abort && !ctl_w |=> !send_request[$past(tx_index)])
      else $error("request kept after abort");
   req_rise_a: assert property (|(send_request & ~$past(send_request)) |-> $past(ctl_w))
      else $error("request rose without a write");
   dir_chg_a: assert property (buffer_direction_select != $past(buffer_direction_select)
      |-> $past(ctl_w)) else $error("direction changed without a write");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   rdata_hold_a: assert property (psel && penable |-> pready ##1 $stable(prdata))
      else $error("read data moved after access phase");
   irq_clear_a: assert property (isr_w && !rx_store && !tx_done && !tx_abort && !tx_fault
      && !$past(rx_store || tx_done || tx_abort || tx_fault)
      |=> !irq) else $error("irq stayed after status read");
   cover property (rx_store && rx_buffer_occupied[rx_index]);
   cover property (irq);
   cover property (pslverr);
endmodule : cbo_buf_status_monitor
bind cbo_buf_status cbo_buf_status_monitor cbo_buf_status_monitor_i (.*);

// ---- bench/cbo_buf_status_tb.sv ----
`timescale 1ns/1ns
module cbo_buf_status_tb;
   logic        mclk, rst, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic        rx_store, tx_done, tx_abort, tx_lost_arb, tx_fault;
   logic [4:0]  rx_index, tx_index;
   logic [31:0] rx_buffer_occupied, send_request, buffer_direction_select;
   logic [31:0] auto_remote_reply_enable;
   logic [63:0] send_priority;
   int          n_fail, checked;
   cbo_buf_status cbo_buf_status_i (.*);
   cbo_engine_model cbo_engine_model_i (.*);
   initial begin
      mclk = 0;
      forever #10 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int k;
      @(posedge mclk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, wr, a, d, s};
      @(posedge mclk);
      penable <= 1;
      for (k = 0; k < 8; k++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      if (k == 8) begin
         n_fail++;
         end_of_test();
      end
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(0, a, 32'h0, 4'h0);
      chk(rd, exp);
   endtask : rdchk
   ////////////////////////////////////////////////////////////////
   task automatic s_reset();
      logic [7:0] ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h4c, 8'h50, 8'h54};
      foreach (ofs[i]) rdchk(ofs[i], 32'h0);
   endtask : s_reset
   task automatic s_ovf();
      cbo_engine_model_i.fire(0, 5'd3);
      cbo_engine_model_i.fire(0, 5'd3);
      cbo_engine_model_i.fire(0, 5'd20);
      cbo_engine_model_i.fire(0, 5'd20);
      rdchk(cbo_pkg::OFS_FUL_LO, 32'h8);
      rdchk(cbo_pkg::OFS_OVF_LO, 32'h8);
      rdchk(cbo_pkg::OFS_OVF_HI, 32'h10);
      rdchk(cbo_pkg::OFS_FUL_HI, 32'h10);
      // a clear with only one byte strobe is refused
      apb(1, cbo_pkg::OFS_OVF_HI, 32'h0, 4'h1);
      rdchk(cbo_pkg::OFS_OVF_HI, 32'h10);
      apb(1, cbo_pkg::OFS_OVF_LO, 32'hffff, 4'h3);
      rdchk(cbo_pkg::OFS_OVF_LO, 32'h8);
      apb(1, cbo_pkg::OFS_OVF_LO, 32'h0, 4'h3);
      rdchk(cbo_pkg::OFS_OVF_LO, 32'h0);
      apb(1, cbo_pkg::OFS_FUL_LO, 32'h0, 4'h3);
      rdchk(cbo_pkg::OFS_FUL_LO, 32'h0);
      // buffer empty again, so this store must not overflow
      cbo_engine_model_i.fire(0, 5'd3);
      rdchk(cbo_pkg::OFS_OVF_LO, 32'h0);
      rdchk(cbo_pkg::OFS_OVF_HI, 32'h10);
   endtask : s_ovf
   task automatic s_irq();
      apb(0, cbo_pkg::OFS_INT_STAT, 32'h0, 4'h0);
      apb(1, cbo_pkg::OFS_INT_MASK, 32'h1, 4'h1);
      cbo_engine_model_i.fire(0, 5'd3);
      @(negedge mclk);
      chk(32'(irq), 32'h1);
      rdchk(cbo_pkg::OFS_INT_STAT, 32'h1);
      @(negedge mclk);
      chk(32'(irq), 32'h0);
      apb(1, cbo_pkg::OFS_INT_MASK, 32'h0, 4'h1);
      cbo_engine_model_i.fire(0, 5'd3);
      @(negedge mclk);
      chk(32'(irq), 32'h0);
      rdchk(cbo_pkg::OFS_INT_STAT, 32'h1);
   endtask : s_irq
   task automatic s_tx();
      apb(1, cbo_pkg::OFS_TXC_BASE, 32'hffff, 4'h1);
      rdchk(cbo_pkg::OFS_TXC_BASE, 32'h8f);
      chk({28'h0, send_request[0], buffer_direction_select[0], send_priority[1:0]}, 32'hf);
      chk(32'(auto_remote_reply_enable[0]), 32'h1);
      cbo_engine_model_i.fire(4, 5'd0);
      rdchk(cbo_pkg::OFS_TXC_BASE, 32'h9f);
      cbo_engine_model_i.fire(3, 5'd0);
      rdchk(cbo_pkg::OFS_TXC_BASE, 32'hbf);
      cbo_engine_model_i.fire(2, 5'd0);
      rdchk(cbo_pkg::OFS_TXC_BASE, 32'hf7);
      apb(1, cbo_pkg::OFS_TXC_BASE, 32'h8f, 4'h1);
      rdchk(cbo_pkg::OFS_TXC_BASE, 32'h8f);
      cbo_engine_model_i.fire(1, 5'd0);
      rdchk(cbo_pkg::OFS_TXC_BASE, 32'h87);
      // fault and abort raise bit 2, the send raises bit 1
      rdchk(cbo_pkg::OFS_INT_STAT, 32'h6);
      for (int p = 0; p < 4; p++) begin
         apb(1, cbo_pkg::OFS_TXC_BASE, 32'(p << 8), 4'h2);
         // the write lands at the access edge, so look once it has settled
         @(negedge mclk);
         chk({30'h0, send_priority[3:2]}, 32'(p));
      end
   endtask : s_tx
   task automatic s_bad();
      rdchk(8'h60, 32'h0);
      chk(32'(err), 32'h1);
   endtask : s_bad
   ////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      end_of_test();
   end
   initial begin
      n_fail = 0;
      checked = 0;
      rst = 1;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      repeat (16) @(posedge mclk);
      rst <= 0;
      s_reset();
      s_ovf();
      s_irq();
      s_tx();
      s_bad();
      end_of_test();
   end
endmodule : cbo_buf_status_tb
